// [shared/pta_regs.vh]
// Register map, field positions and codes of the product-term macrocell array
//
// Contract
// RULE1 - Block selectable per block to run as product-term macrocells instead of memory.
// RULE2 - Macrocell operation takes 32 logic inputs from the adjacent local routing.
// RULE3 - Nine macrocell outputs feed back into the block inputs through local routing.
// RULE4 - Sixteen macrocells, each with two product terms and one storage register.
// RULE5 - Each macrocell sequential or combinational; combinational bypasses the register.
// RULE6 - Per-macrocell matrix sends each product term to own OR/XOR or lends it.
// RULE7 - One product term per macrocell has configurable inversion for De Morgan use.
// RULE8 - Each register individually configurable as D, T, JK or SR flip-flop.
// RULE9 - Each register clocked by a chosen one of two block-wide clocks.
// RULE10 - Each block clock sourced from dedicated pin, global signal or local routing.
// RULE11 - Each block clock has its own gate; a macrocell uses its clock's gate.
// RULE12 - Mixed rising and falling capture uses both block clocks, one per edge.
// RULE13 - Two clears from global or local signals, each optionally inverted in block.
// RULE14 - Each register responds to clear a, clear b, or no clear.
// RULE15 - OR gate takes up to 32 terms: own two plus 30 borrowed.
// RULE16 - Expanders come in up to 15 sets of two; each set adds delay.
// RULE17 - Four dedicated clock pins are available as block clock sources.
// RULE18 - Deasserted gate holds register on edges; clear acts regardless of gate.
`ifndef PTA_REGS_VH
`define PTA_REGS_VH

// Geometry
`define PTA_N_IN 32
`define PTA_N_MC 16
`define PTA_N_FB 9
`define PTA_N_PIN 4
`define PTA_N_GLB 4

// Register offsets (byte addresses)
`define PTA_ADDR_W 10
`define PTA_OFS_CTRL 10'h000
`define PTA_OFS_STAT 10'h004
`define PTA_OFS_CFG 10'h040
`define PTA_OFS_MASK 10'h100

// Block control fields
`define PTA_CTRL_MODE 0
`define PTA_CTRL_CKA_SRC 1
`define PTA_CTRL_CKA_FALL 4
`define PTA_CTRL_CKB_SRC 5
`define PTA_CTRL_CKB_FALL 8
`define PTA_CTRL_CLA_LOC 9
`define PTA_CTRL_CLA_INV 10
`define PTA_CTRL_CLB_LOC 11
`define PTA_CTRL_CLB_INV 12
`define PTA_CTRL_FB_EN 13
`define PTA_CTRL_W 14
`define PTA_CTRL_RST 14'h0000

// Macrocell configuration fields
`define PTA_CFG_REG 0
`define PTA_CFG_TYPE 1
`define PTA_CFG_CLK_B 3
`define PTA_CFG_CLR 4
`define PTA_CFG_INV1 6
`define PTA_CFG_LEND0 7
`define PTA_CFG_LEND1 8
`define PTA_CFG_TAKE 9
`define PTA_CFG_PASS 10
`define PTA_CFG_OINV 11
`define PTA_CFG_W 12
`define PTA_CFG_RST 12'h000

// Clock source codes
`define PTA_SRC_GLOBAL 3'h4
`define PTA_SRC_LOCAL 3'h5

// Register types
`define PTA_FF_D 2'h0
`define PTA_FF_T 2'h1
`define PTA_FF_JK 2'h2
`define PTA_FF_SR 2'h3

// Clear selection codes
`define PTA_CLR_NONE 2'h0
`define PTA_CLR_A 2'h1
`define PTA_CLR_B 2'h2

// Global lines used as clock and clear sources
`define PTA_GLB_CKA 0
`define PTA_GLB_CKB 1
`define PTA_GLB_CLA 2
`define PTA_GLB_CLB 3

`endif

// [src/pta_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pta_sync #(
   parameter W = 1
) (
   input wire clock, // System clock
   input wire rstn, // Asynchronous reset, active low
   input wire [W-1:0] async_in, // Signals from outside the clock domain
   output reg [W-1:0] sync_q // Accepted values
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   // Shift chain; a bit is accepted once stages two and three agree
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         sync_q <= (s2_q & ~(s2_q ^ s3_q)) | (sync_q & (s2_q ^ s3_q));
      end
   end
endmodule // pta_sync

// [src/pta_macrocell.v]
// Programmable storage register of one macrocell
`timescale 1ns/10ps
`include "pta_regs.vh"
module pta_macrocell (
   input wire clock, // System clock
   input wire rstn, // Asynchronous reset, active low
   input wire tick, // Selected block clock edge, already gated
   input wire clr, // Selected block clear, active high
   input wire [1:0] ff_type, // Register behaviour
   input wire d_in, // Logic result (D and T data)
   input wire j_in, // Set term for JK and SR
   input wire k_in, // Reset term for JK and SR
   output reg q_q // Register state
);
   reg q_d;

   // Next state per register type
   always @*
   begin
      case (ff_type)
         `PTA_FF_D: q_d = d_in; // RULE8
         `PTA_FF_T: q_d = q_q ^ d_in; // RULE8
         `PTA_FF_JK: q_d = (j_in & ~q_q) | (~k_in & q_q); // RULE8
         `PTA_FF_SR: q_d = j_in | (~k_in & q_q); // RULE8
         default: q_d = q_q;
      endcase
   end

   // Clear has priority and ignores the gate; no edge means hold
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         q_q <= 1'b0;
      else if (clr)
         q_q <= 1'b0; // RULE18
      else if (tick)
         q_q <= q_d; // RULE18
   end
endmodule // pta_macrocell

// [src/pta_array.v]
// Embedded block operated as a 16-macrocell product-term array
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "pta_regs.vh"
module pta_array (
   input wire clock, // System clock, 100 MHz
   input wire rstn, // Asynchronous reset, active low
   input wire [9:0] addr, // Register byte address
   input wire [31:0] wdata, // Register write data
   input wire wr, // Write strobe
   input wire rd, // Read strobe
   output reg [31:0] rdata, // Read data, valid the cycle after rd
   input wire [31:0] logic_in, // Logic inputs from local routing
   input wire [3:0] clk_pin, // Dedicated clock pins
   input wire [3:0] global_sig, // Global signals
   input wire local_clk_a, // Local routing source for clock a
   input wire local_clk_b, // Local routing source for clock b
   input wire block_clock_a_gate, // Enable paired with clock a
   input wire block_clock_b_gate, // Enable paired with clock b
   input wire local_clr_a, // Local routing source for clear a
   input wire local_clr_b, // Local routing source for clear b
   output reg [15:0] mc_out // Macrocell outputs
);
   localparam SW = 46;

   reg [`PTA_CTRL_W-1:0] ctrl_q;
   reg [`PTA_CFG_W-1:0] cfg_q [0:`PTA_N_MC-1];
   reg [31:0] mask_q [0:4*`PTA_N_MC-1];
   reg cka_prev_q;
   reg ckb_prev_q;
   integer k;

   wire [SW-1:0] raw_in;
   wire [SW-1:0] syn;
   wire [31:0] lin_s;
   wire [3:0] pin_s;
   wire [3:0] glb_s;
   wire lcka_s;
   wire lckb_s;
   wire gate_a_s;
   wire gate_b_s;
   wire lcla_s;
   wire lclb_s;

   wire mode;
   wire [31:0] pt_in;
   wire cka_lvl;
   wire ckb_lvl;
   wire cka_edge;
   wire ckb_edge;
   wire tick_a;
   wire tick_b;
   wire clr_a;
   wire clr_b;
   wire [`PTA_N_MC:0] exp_c;
   wire [`PTA_N_MC-1:0] logic_r;
   wire [`PTA_N_MC-1:0] reg_q;
   wire [`PTA_N_MC-1:0] mc_d;

   wire wr_ctrl;
   wire wr_cfg;
   wire wr_mask;

   // Every routing, pin and global input enters through one synchroniser; the bus signals do not
   assign raw_in = {local_clr_b, local_clr_a, block_clock_b_gate,
                    block_clock_a_gate, local_clk_b, local_clk_a,
                    global_sig, clk_pin, logic_in};

   pta_sync #(
      .W(SW)
   ) u_sync (
      .clock(clock),
      .rstn(rstn),
      .async_in(raw_in),
      .sync_q(syn)
   );

   // Split the accepted vector back into named signals
   assign lin_s = syn[31:0]; // RULE2
   assign pin_s = syn[35:32];
   assign glb_s = syn[39:36];
   assign lcka_s = syn[40];
   assign lckb_s = syn[41];
   assign gate_a_s = syn[42];
   assign gate_b_s = syn[43];
   assign lcla_s = syn[44];
   assign lclb_s = syn[45];

   // Block operating mode
   assign mode = ctrl_q[`PTA_CTRL_MODE]; // RULE1

   // Feedback of the first nine macrocell outputs into the input set
   assign pt_in = ctrl_q[`PTA_CTRL_FB_EN] ?
                  {lin_s[31:`PTA_N_FB], mc_out[`PTA_N_FB-1:0]} :
                  lin_s; // RULE3

   // Clock source selection: four pins, a global line or local routing
   function pta_clk_src;
      input [2:0] src;
      input [3:0] pins;
      input glb;
      input loc;
      begin
         if (src == `PTA_SRC_GLOBAL)
            pta_clk_src = glb;
         else if (src == `PTA_SRC_LOCAL)
            pta_clk_src = loc;
         else if (src < `PTA_SRC_GLOBAL)
            pta_clk_src = pins[src[1:0]]; // RULE17
         else
            pta_clk_src = 1'b0;
      end
   endfunction

   assign cka_lvl = pta_clk_src(ctrl_q[`PTA_CTRL_CKA_SRC+2:`PTA_CTRL_CKA_SRC],
                                pin_s, glb_s[`PTA_GLB_CKA], lcka_s); // RULE10
   assign ckb_lvl = pta_clk_src(ctrl_q[`PTA_CTRL_CKB_SRC+2:`PTA_CTRL_CKB_SRC],
                                pin_s, glb_s[`PTA_GLB_CKB], lckb_s); // RULE10

   // Previous levels of the two block clocks for edge detection
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         cka_prev_q <= 1'b0;
         ckb_prev_q <= 1'b0;
      end
      else
      begin
         cka_prev_q <= cka_lvl;
         ckb_prev_q <= ckb_lvl;
      end
   end

   // Each block clock captures on its own chosen edge
   assign cka_edge = ctrl_q[`PTA_CTRL_CKA_FALL] ?
                     (cka_prev_q & ~cka_lvl) :
                     (~cka_prev_q & cka_lvl); // RULE12
   assign ckb_edge = ctrl_q[`PTA_CTRL_CKB_FALL] ?
                     (ckb_prev_q & ~ckb_lvl) :
                     (~ckb_prev_q & ckb_lvl); // RULE12

   // Edges qualified by the paired gate and by macrocell mode
   assign tick_a = cka_edge & gate_a_s & mode; // RULE11
   assign tick_b = ckb_edge & gate_b_s & mode; // RULE11

   // Block clears from a global line or local routing, optionally inverted
   assign clr_a = (ctrl_q[`PTA_CTRL_CLA_LOC] ? lcla_s : glb_s[`PTA_GLB_CLA]) ^
                  ctrl_q[`PTA_CTRL_CLA_INV]; // RULE13
   assign clr_b = (ctrl_q[`PTA_CTRL_CLB_LOC] ? lclb_s : glb_s[`PTA_GLB_CLB]) ^
                  ctrl_q[`PTA_CTRL_CLB_INV]; // RULE13

   // The last macrocell has no neighbour to borrow from
   assign exp_c[`PTA_N_MC] = 1'b0;

   // One slice per macrocell: product terms, select matrix, register
   genvar i;
   generate
      for (i = 0; i < `PTA_N_MC; i = i + 1)
      begin : g_mc
         wire [`PTA_CFG_W-1:0] cfg;
         wire [31:0] t0;
         wire [31:0] c0;
         wire [31:0] t1;
         wire [31:0] c1;
         wire pt0;
         wire pt1_raw;
         wire pt1;
         wire lend0;
         wire lend1;
         wire lent;
         wire sum;
         wire clr_sel;
         wire tick_sel;

         assign cfg = cfg_q[i];
         assign t0 = mask_q[4*i];
         assign c0 = mask_q[4*i+1];
         assign t1 = mask_q[4*i+2];
         assign c1 = mask_q[4*i+3];

         // Two AND terms over true and complement literals
         assign pt0 = &(~t0 | pt_in) & &(~c0 | ~pt_in); // RULE4
         assign pt1_raw = &(~t1 | pt_in) & &(~c1 | ~pt_in); // RULE4
         assign pt1 = pt1_raw ^ cfg[`PTA_CFG_INV1]; // RULE7

         // Select matrix: a term goes to the own OR gate or is lent
         assign lend0 = cfg[`PTA_CFG_LEND0]; // RULE6
         assign lend1 = cfg[`PTA_CFG_LEND1]; // RULE6
         assign lent = (lend0 & pt0) | (lend1 & pt1); // RULE6

         // Expander chain; every set passed along adds one gate level
         assign exp_c[i] = lent | (cfg[`PTA_CFG_PASS] & exp_c[i+1]); // RULE16

         // OR of own terms plus borrowed sets, then the XOR polarity gate
         assign sum = (~lend0 & pt0) | (~lend1 & pt1) |
                      (cfg[`PTA_CFG_TAKE] & exp_c[i+1]); // RULE15
         assign logic_r[i] = sum ^ cfg[`PTA_CFG_OINV]; // RULE6

         // Clock and clear selection for this register
         assign tick_sel = cfg[`PTA_CFG_CLK_B] ? tick_b : tick_a; // RULE9
         assign clr_sel = (cfg[`PTA_CFG_CLR+1:`PTA_CFG_CLR] == `PTA_CLR_A) ?
                          clr_a :
                          (cfg[`PTA_CFG_CLR+1:`PTA_CFG_CLR] == `PTA_CLR_B) ?
                          clr_b : 1'b0; // RULE14

         pta_macrocell u_mc (
            .clock(clock),
            .rstn(rstn),
            .tick(tick_sel),
            .clr(clr_sel),
            .ff_type(cfg[`PTA_CFG_TYPE+1:`PTA_CFG_TYPE]),
            .d_in(logic_r[i]),
            .j_in(pt0),
            .k_in(pt1),
            .q_q(reg_q[i])
         );

         // Registered or bypassed result; zero outside macrocell mode
         assign mc_d[i] = mode & (cfg[`PTA_CFG_REG] ? reg_q[i] : logic_r[i]); // RULE5
      end
   endgenerate

   // Output stage
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         mc_out <= 16'h0000;
      else
         mc_out <= mc_d; // RULE5
   end

   // Write decode
   assign wr_ctrl = wr & (addr == `PTA_OFS_CTRL);
   assign wr_cfg = wr & (addr[9:6] == `PTA_OFS_CFG >> 6) & (addr[1:0] == 2'h0);
   assign wr_mask = wr & (addr[9:8] == `PTA_OFS_MASK >> 8) & (addr[1:0] == 2'h0);

   // Configuration storage
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_q <= `PTA_CTRL_RST;
         for (k = 0; k < `PTA_N_MC; k = k + 1)
            cfg_q[k] <= `PTA_CFG_RST;
         for (k = 0; k < 4*`PTA_N_MC; k = k + 1)
            mask_q[k] <= 32'h0000_0000;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= wdata[`PTA_CTRL_W-1:0]; // RULE1
         if (wr_cfg)
            cfg_q[addr[5:2]] <= wdata[`PTA_CFG_W-1:0];
         if (wr_mask)
            mask_q[addr[7:2]] <= wdata;
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rdata <= 32'h0000_0000;
      else if (!rd)
         rdata <= 32'h0000_0000;
      else if (addr == `PTA_OFS_CTRL)
         rdata <= {18'h0_0000, ctrl_q};
      else if (addr == `PTA_OFS_STAT)
         rdata <= {16'h0000, mc_out};
      else if ((addr[9:6] == `PTA_OFS_CFG >> 6) && (addr[1:0] == 2'h0))
         rdata <= {20'h0_0000, cfg_q[addr[5:2]]};
      else if ((addr[9:8] == `PTA_OFS_MASK >> 8) && (addr[1:0] == 2'h0))
         rdata <= mask_q[addr[7:2]];
      else
         rdata <= 32'h0000_0000;
   end
endmodule // pta_array

// [dv/pta_chk.sv]
// Port checker for the product-term macrocell array
`timescale 1ns/10ps
module pta_chk (
   input wire clock, // System clock
   input wire rstn, // Reset, active low
   input wire [9:0] addr, // Byte address
   input wire [31:0] wdata, // Write data
   input wire wr, // Write strobe
   input wire rd, // Read strobe
   input wire [31:0] rdata, // Read data
   input wire [15:0] mc_out // Macrocell outputs
);
   reg [13:0] ctrl_q;
   // Shadow of the control register as written over the bus
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         ctrl_q <= 14'h0000;
      else if (wr && addr == 10'h000)
         ctrl_q <= wdata[13:0];
   end
   // Bus read behaviour and output gating
   idle_rdata_a: assert property (@(posedge clock) disable iff (!rstn)
      !$past(rd) |-> rdata == 32'h0000_0000) else $error("rdata not zero when idle");
   stat_read_a: assert property (@(posedge clock) disable iff (!rstn)
      rd && addr == 10'h004 |=> rdata == {16'h0000, $past(mc_out)})
      else $error("status read differs from outputs");
   unmapped_read_a: assert property (@(posedge clock) disable iff (!rstn)
      rd && addr == 10'h008 |=> rdata == 32'h0000_0000) else $error("unmapped read not zero");
   ctrl_read_a: assert property (@(posedge clock) disable iff (!rstn)
      rd && addr == 10'h000 |=> rdata == {18'h0_0000, ctrl_q}) else $error("control readback");
   narrow_read_a: assert property (@(posedge clock) disable iff (!rstn)
      rd && addr[9:6] == 4'h1 |=> rdata[31:12] == 20'h0_0000) else $error("config upper bits");
   mode_off_a: assert property (@(posedge clock) disable iff (!rstn)
      !ctrl_q[0] && !$past(ctrl_q[0], 3) |-> mc_out == 16'h0000) else $error("outputs while off");
   reset_zero_a: assert property (@(posedge clock)
      !rstn |-> mc_out == 16'h0000 && rdata == 32'h0000_0000) else $error("not zero in reset");
   high_read_a: assert property (@(posedge clock) disable iff (!rstn)
      rd && addr[9:8] == 2'h0 |=> rdata[31:16] == 16'h0000) else $error("upper half not zero");
   // Main scenarios reached
   cover property (@(posedge clock) rd && addr == 10'h004 && mc_out != 16'h0000);
   cover property (@(posedge clock) $rose(ctrl_q[0]));
   cover property (@(posedge clock) $changed(mc_out) && ctrl_q[13]);
endmodule // pta_chk

bind pta_array pta_chk u_chk (
   .clock(clock),
   .rstn(rstn),
   .addr(addr),
   .wdata(wdata),
   .wr(wr),
   .rd(rd),
   .rdata(rdata),
   .mc_out(mc_out)
);

// [dv/pta_route_model.sv]
// Routing model driving logic inputs, block clocks, gates and clears
`timescale 1ns/10ps
module pta_route_model (
   input wire clock, // System clock
   output reg [31:0] logic_in, // Logic inputs
   output wire [3:0] clk_pin, // Dedicated clock pins
   output wire [3:0] global_sig, // Global lines
   output wire local_clk_a, // Local clock a
   output wire local_clk_b, // Local clock b
   output wire block_clock_a_gate, // Gate a
   output wire block_clock_b_gate, // Gate b
   output wire local_clr_a, // Local clear a
   output wire local_clr_b // Local clear b
);
   reg [7:0] clk_q = 8'h00;
   reg [3:0] clr_q = 4'h0;
   reg [1:0] gate_q = 2'h3;
   initial logic_in = 32'h0000_0000;
   // Clock lines rest low between pulses: four pins, globals, local lines
   assign clk_pin = clk_q[3:0];
   assign global_sig = {clr_q[1:0], clk_q[5:4]};
   assign local_clk_a = clk_q[6];
   assign local_clk_b = clk_q[7];
   assign block_clock_a_gate = gate_q[0];
   assign block_clock_b_gate = gate_q[1];
   assign local_clr_a = clr_q[2];
   assign local_clr_b = clr_q[3];
   // Apply levels after an edge and let them settle through the sync chain
   task put(input [31:0] v, input [1:0] g, input [3:0] c);
   begin
      @(posedge clock);
      logic_in <= v;
      gate_q <= g;
      clr_q <= c;
      repeat (9) @(posedge clock);
   end
   endtask
   // One clock line level held long enough to be seen
   task lvl(input integer n, input v);
   begin
      @(posedge clock);
      clk_q[n] <= v;
      repeat (9) @(posedge clock);
   end
   endtask
endmodule // pta_route_model

// [dv/pta_array_tb_top.sv]
// Self-checking bench for the macrocell array
`timescale 1ns/10ps
module pta_array_tb_top;
   reg clock = 1'b0;
   reg rstn = 1'b1;
   reg [9:0] addr = 10'h000;
   reg [31:0] wdata = 32'h0000_0000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [5:0] tbl [0:3];
   wire [31:0] rdata, logic_in;
   wire [15:0] mc_out;
   wire [3:0] clk_pin, global_sig;
   wire local_clk_a, local_clk_b, block_clock_a_gate, block_clock_b_gate;
   wire local_clr_a, local_clr_b;
   integer num_errors = 0;
   integer n_compared = 0;
   integer cyc = 0;
   integer t;
   // Design and routing model
   pta_array DUT (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .logic_in(logic_in), .clk_pin(clk_pin),
      .global_sig(global_sig), .local_clk_a(local_clk_a), .local_clk_b(local_clk_b),
      .block_clock_a_gate(block_clock_a_gate), .block_clock_b_gate(block_clock_b_gate),
      .local_clr_a(local_clr_a), .local_clr_b(local_clr_b), .mc_out(mc_out));
   pta_route_model rm (.clock(clock), .logic_in(logic_in), .clk_pin(clk_pin),
      .global_sig(global_sig), .local_clk_a(local_clk_a), .local_clk_b(local_clk_b),
      .block_clock_a_gate(block_clock_a_gate), .block_clock_b_gate(block_clock_b_gate),
      .local_clr_a(local_clr_a), .local_clr_b(local_clr_b));
   // Clock and hang limit
   always #5 clock = ~clock;
   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (cyc == 12000)
      begin
         num_errors = num_errors + 1;
         end_sim;
      end
   end
   task end_sim;
   begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   task chk(input [31:0] got, input [31:0] e);
   begin
      n_compared = n_compared + 1;
      if (got !== e)
      begin
         num_errors = num_errors + 1;
         $display("ERROR %0t got %h expected %h", $time, got, e);
      end
   end
   endtask
   task cb(input integer i, input e);
   begin
      #1 chk({31'h0000_0000, mc_out[i]}, {31'h0000_0000, e});
   end
   endtask
   // Bus cycles: one-cycle strobes, read data in the following cycle
   task wreg(input [9:0] a, input [31:0] d);
   begin
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   end
   endtask
   task rchk(input [9:0] a, input [31:0] e);
   begin
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(rdata, e);
   end
   endtask
   function [9:0] mk(input integer i, input integer k);
      mk = 10'h100 + 4 * (4 * i + k);
   endfunction
   function [9:0] cf(input integer i);
      cf = 10'h040 + 4 * i;
   endfunction
   task pi(input [31:0] v);
      rm.put(v, 2'h3, 4'h0);
   endtask
   task pa(input integer n);
   begin
      rm.lvl(n, 1'b1);
      rm.lvl(n, 1'b0);
   end
   endtask
   task step(input j, input k, input e);
   begin
      pi({7'h00, k, j, 23'h00_0000});
      pa(0);
      cb(3, e);
   end
   endtask
   // Scenarios
   task t_regs;
   begin
      rchk(10'h000, 32'h0000_0000);
      rchk(10'h008, 32'h0000_0000);
      wreg(10'h000, 32'hFFFF_FFFF);
      rchk(10'h000, 32'h0000_3FFF);
      wreg(cf(0), 32'hFFFF_FFFF);
      rchk(cf(0), 32'h0000_0FFF);
      wreg(cf(0), 32'h0000_0000);
      wreg(10'h000, 32'h0000_0001);
      pi(32'h0000_0000);
      rchk(10'h004, 32'h0000_FFFF);
      wreg(10'h000, 32'h0000_0000);
      pi(32'h0000_0000);
      rchk(10'h004, 32'h0000_0000);
   end
   endtask
   task t_comb;
   begin
      wreg(10'h000, 32'h0000_09A1);
      wreg(mk(0, 0), 32'h8010_0000);
      wreg(mk(0, 2), 32'h0010_0000);
      wreg(mk(0, 3), 32'h0010_0000);
      pi(32'h8010_0000);
      cb(0, 1'b1);
      pi(32'h0010_0000);
      cb(0, 1'b0);
      wreg(cf(0), 32'h0000_0040);
      pi(32'h0010_0000);
      cb(0, 1'b1);
      wreg(cf(0), 32'h0000_0840);
      pi(32'h0010_0000);
      cb(0, 1'b0);
      wreg(cf(0), 32'h0000_0080);
      pi(32'h8010_0000);
      cb(0, 1'b0);
   end
   endtask
   task t_exp;
   begin
      wreg(mk(1, 0), 32'h0020_0000);
      wreg(mk(2, 0), 32'h0040_0000);
      wreg(cf(2), 32'h0000_0080);
      wreg(cf(1), 32'h0000_0480);
      wreg(cf(0), 32'h0000_0280);
      pi(32'h0020_0000);
      cb(0, 1'b1);
      pi(32'h0040_0000);
      cb(0, 1'b1);
      pi(32'h0000_0000);
      cb(0, 1'b0);
   end
   endtask
   task t_ff;
   begin
      wreg(mk(3, 0), 32'h0080_0000);
      wreg(mk(3, 2), 32'h0100_0000);
      for (t = 0; t < 4; t = t + 1)
      begin
         wreg(cf(3), 2 * t + 1);
         step(tbl[t][5], tbl[t][4], tbl[t][3]);
         step(tbl[t][2], tbl[t][1], tbl[t][0]);
      end
      wreg(cf(3), 32'h0000_0001);
      rm.put(32'h0080_0000, 2'h2, 4'h0);
      pa(0);
      cb(3, 1'b0);
      pi(32'h0080_0000);
      pa(0);
      cb(3, 1'b1);
      wreg(cf(3), 32'h0000_0009);
      pi(32'h0000_0000);
      rm.lvl(7, 1'b1);
      cb(3, 1'b1);
      rm.lvl(7, 1'b0);
      cb(3, 1'b0);
      pi(32'h0080_0000);
      pa(0);
      cb(3, 1'b0);
   end
   endtask
   task t_src;
   begin
      wreg(cf(3), 32'h0000_0001);
      for (t = 0; t < 7; t = t + 1)
      begin
         wreg(10'h000, 32'h0000_09A1 | (t << 1));
         pi({8'h00, ~t[0], 23'h00_0000});
         pa(t < 4 ? t : (t == 4 ? 4 : 6));
         cb(3, t < 6 ? ~t[0] : 1'b0);
      end
      // Clock a on its falling edge: the rise must not load
      wreg(10'h000, 32'h0000_09B1);
      pi(32'h0080_0000);
      rm.lvl(0, 1'b1);
      cb(3, 1'b0);
      rm.lvl(0, 1'b0);
      cb(3, 1'b1);
   end
   endtask
   task t_clr;
   begin
      wreg(10'h000, 32'h0000_09A1);
      wreg(cf(3), 32'h0000_0011);
      pi(32'h0080_0000);
      pa(0);
      cb(3, 1'b1);
      rm.put(32'h0080_0000, 2'h0, 4'h1);
      cb(3, 1'b0);
      wreg(10'h000, 32'h0000_0DA1);
      rm.put(32'h0080_0000, 2'h3, 4'h1);
      pa(0);
      cb(3, 1'b1);
      pi(32'h0080_0000);
      cb(3, 1'b0);
      wreg(10'h000, 32'h0000_09A1);
      wreg(cf(3), 32'h0000_0021);
      pa(0);
      cb(3, 1'b1);
      rm.put(32'h0080_0000, 2'h3, 4'h8);
      cb(3, 1'b0);
      wreg(cf(3), 32'h0000_0001);
      pa(0);
      cb(3, 1'b1);
      // Clear a taken from local routing
      wreg(10'h000, 32'h0000_0BA1);
      wreg(cf(3), 32'h0000_0011);
      rm.put(32'h0080_0000, 2'h3, 4'h4);
      cb(3, 1'b0);
      wreg(cf(3), 32'h0000_0001);
      pa(0);
      cb(3, 1'b1);
   end
   endtask
   task t_fb;
   begin
      wreg(10'h000, 32'h0000_29A1);
      wreg(mk(4, 0), 32'h0000_0008);
      wreg(mk(4, 2), 32'h0000_0008);
      wreg(mk(4, 3), 32'h0000_0008);
      pi(32'h0000_0000);
      cb(4, 1'b1);
      wreg(cf(3), 32'h0000_0021);
      rm.put(32'h0000_0008, 2'h3, 4'h8);
      cb(4, 1'b0);
   end
   endtask
   // Main sequence
   initial
   begin
      rstn <= 1'b0;
      tbl[0] = 6'h28;
      tbl[1] = 6'h2C;
      tbl[2] = 6'h2E;
      tbl[3] = 6'h3A;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      t_regs;
      t_comb;
      t_exp;
      t_ff;
      t_src;
      t_clr;
      t_fb;
      end_sim;
   end
endmodule // pta_array_tb_top
